// >>> rtl/adc_ctrl_pkg.sv
// Package with shared constants and carrier types for the conversion control block.
package adc_ctrl_pkg;

  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int unsigned RESULT_W   = 8;
  localparam int unsigned NIBBLE_W   = 4;
  localparam int unsigned CODE_STEPS = 256;
  localparam int unsigned SAR_BITS   = 8;
  localparam int unsigned SETTLE_CYC = 2;
  localparam int unsigned CNT_W      = 4;

  // ****************************************************************
  // Reset and start values
  // ****************************************************************
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] SAR_TOP    = 8'h80;
  localparam logic [3:0] CNT_ZERO   = 4'h0;

  // Host strobe group, all active low.
  typedef struct packed {
    logic select_n;
    logic start_n;
    logic read_n;
  } host_strobe_s;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_HOLD   = 2'b01,
    ST_SETTLE = 2'b10,
    ST_TRIAL  = 2'b11
  } seq_state_e;

endpackage : adc_ctrl_pkg

// >>> rtl/adc_conversion_restart_control.sv
// Conversion sequencer, restart handling, output latch and bus drive of the 8-bit converter.
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_restart_control #(
  parameter int unsigned RES_W  = adc_ctrl_pkg::RESULT_W,
  parameter int unsigned SETTLE = adc_ctrl_pkg::SETTLE_CYC
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  input  wire logic                       i_ce,
  input  wire adc_ctrl_pkg::host_strobe_s i_strobe,
  input  wire logic                       i_clk_pin_level,
  input  wire logic                       i_comp_above,
  output logic [RES_W-1:0]                o_trial_code,
  output logic                            o_sample_hold,
  output logic                            o_conversion_done_n,
  output logic [RES_W-1:0]                o_data,
  output logic                            o_data_oe,
  output logic                            o_conv_clk
);
  import adc_ctrl_pkg::*;

  // ****************************************************************
  // Conversion clock conditioning
  // ****************************************************************

  // Schmitt stage: the level only flips after two agreeing samples, so a slow
  // edge that chatters around the threshold yields one clean transition.
  logic       clk_lvl_q,  clk_lvl_d;
  logic       clk_s1_q,   clk_s1_d;
  logic       clk_rise;

  always_comb begin
    clk_s1_d  = i_clk_pin_level;
    clk_lvl_d = clk_lvl_q;
    if (clk_s1_q == i_clk_pin_level) begin
      clk_lvl_d = clk_s1_q;
    end
  end

  // A rise is flagged from the next level so the sequencer acts on it at once.
  assign clk_rise = clk_lvl_d & ~clk_lvl_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      clk_s1_q  <= 1'b0;
      clk_lvl_q <= 1'b0;
    end else if (i_ce) begin
      clk_s1_q  <= clk_s1_d;
      clk_lvl_q <= clk_lvl_d;
    end
  end

  // ****************************************************************
  // Start strobe detection
  // ****************************************************************

  // The start takes effect on the trailing edge of the select and start pair.
  // Waiting for the trailing edge means a host that holds the pair low for
  // several cycles still launches exactly one conversion, at its release.
  logic wr_act_q, wr_act_d;
  logic start_evt;

  always_comb begin
    wr_act_d  = ~i_strobe.select_n & ~i_strobe.start_n;
    start_evt = wr_act_q & ~wr_act_d;
  end

  // ****************************************************************
  // Successive approximation sequencer
  // ****************************************************************

  // Trial weight of the first step, the most significant bit.
  function automatic logic [RES_W-1:0] top_bit();
    top_bit = {1'b1, {(RES_W-1){1'b0}}};
  endfunction : top_bit

  seq_state_e       st_q,     st_d;
  logic [RES_W-1:0] sar_q,    sar_d;
  logic [RES_W-1:0] bit_q,    bit_d;
  logic [CNT_W-1:0] cnt_q,    cnt_d;
  logic [RES_W-1:0] latch_q,  latch_d;
  logic             done_n_q, done_n_d;
  logic             hold_q,   hold_d;
  logic [RES_W-1:0] data_q,   data_d;
  logic             oe_q,     oe_d;
  logic             fin_q,    fin_d;
  logic [RES_W-1:0] kept;

  // Trials advance on conditioned clock rises; a restart overrides everything.
  // A restart reloads the trial register with the top bit and clears the counter rather than
  // letting the current step finish, so an abort never leaks into the latch.
  always_comb begin
    st_d     = st_q;
    sar_d    = sar_q;
    bit_d    = bit_q;
    cnt_d    = cnt_q;
    latch_d  = latch_q;
    done_n_d = done_n_q;
    hold_d   = hold_q;
    kept     = sar_q;
    fin_d    = 1'b0;
    if (start_evt) begin
      st_d     = ST_HOLD;
      sar_d    = top_bit();
      bit_d    = top_bit();
      cnt_d    = CNT_ZERO;
      done_n_d = 1'b1;
      hold_d   = 1'b1;
    end else if (clk_rise) begin
      case (st_q)
        ST_HOLD: begin
          hold_d = 1'b0;
          st_d   = ST_SETTLE;
        end
        ST_SETTLE: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CNT_W'(SETTLE - 1)) begin
            st_d  = ST_TRIAL;
            cnt_d = CNT_ZERO;
          end
        end
        ST_TRIAL: begin
          // The trial bit stays only when the input is at or above the trial code.
          if (!i_comp_above) begin
            kept = sar_q & ~bit_q;
          end
          bit_d = bit_q >> 1;
          sar_d = kept | (bit_q >> 1);
          if (bit_q[0]) begin
            latch_d = kept;
            st_d    = ST_IDLE;
            fin_d   = 1'b1;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
    // The host taking the select and start pair low withdraws the completion,
    // which is what lets a looped done-to-start wire keep free running going.
    if (wr_act_d) begin
      done_n_d = 1'b1;
    end
    // Done goes low one cycle after the latch was written. A completion that
    // meets the host's clear in the same cycle still shows, so none is lost,
    // but a start event wins because it abandons the result being flagged.
    if (fin_q && !start_evt) begin
      done_n_d = 1'b0;
      sar_d    = '0;
    end
  end

  // Read drive: only while select and read are both low.
  // Released data is parked at zero so a bus model that ignores the enable
  // never sees a stale result; the enable is what a pad ring would use.
  always_comb begin
    oe_d   = ~i_strobe.select_n & ~i_strobe.read_n;
    data_d = oe_d ? latch_q : '0;
  end

  // ****************************************************************
  // State registers
  // ****************************************************************

  // Every register of the sequencer holds still while the clock enable is low,
  // so a frozen block resumes exactly where it stopped.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_act_q <= 1'b0;
      fin_q    <= 1'b0;
      st_q     <= ST_IDLE;
      sar_q    <= '0;
      bit_q    <= '0;
      cnt_q    <= CNT_ZERO;
      latch_q  <= RES_W'(RESULT_RST);
      done_n_q <= 1'b1;
      hold_q   <= 1'b0;
      data_q   <= '0;
      oe_q     <= 1'b0;
    end else if (i_ce) begin
      wr_act_q <= wr_act_d;
      fin_q    <= fin_d;
      st_q     <= st_d;
      sar_q    <= sar_d;
      bit_q    <= bit_d;
      cnt_q    <= cnt_d;
      latch_q  <= latch_d;
      done_n_q <= done_n_d;
      hold_q   <= hold_d;
      data_q   <= data_d;
      oe_q     <= oe_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // All outputs come straight from flip-flops.
  // The read path therefore answers one cycle after the strobes fall, which a
  // slow host absorbs easily and a fast one covers with a wait state.
  assign o_trial_code        = sar_q;
  assign o_sample_hold       = hold_q;
  assign o_conversion_done_n = done_n_q;
  assign o_data              = data_q;
  assign o_data_oe           = oe_q;
  assign o_conv_clk          = clk_lvl_q;

endmodule : adc_conversion_restart_control
`default_nettype wire

// >>> testbench/adc_restart_assertions.sv
// Port-level checks of the conversion control block.
`timescale 1ns/10ps
`default_nettype none
module adc_restart_assertions #(
  parameter int unsigned RES_W = 8
) (
  input wire logic                       i_clk,
  input wire logic                       i_reset,
  input wire adc_ctrl_pkg::host_strobe_s i_strobe,
  input wire logic                       i_clk_pin_level,
  input wire logic [RES_W-1:0]           o_trial_code,
  input wire logic                       o_sample_hold,
  input wire logic                       o_conversion_done_n,
  input wire logic [RES_W-1:0]           o_data,
  input wire logic                       o_data_oe,
  input wire logic                       o_conv_clk
);
  import adc_ctrl_pkg::*;
  // Decoded strobe pairs, kept combinational so the properties stay short.
  wire logic start_low = !i_strobe.select_n && !i_strobe.start_n;
  wire logic read_low  = !i_strobe.select_n && !i_strobe.read_n;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_start; $past(start_low) && !start_low |=> o_conversion_done_n && o_sample_hold && o_trial_code == SAR_TOP;
  endproperty
  a_start: assert property (p_start) else $error("start event did not begin a conversion");
  property p_hold; o_sample_hold |-> o_conversion_done_n; endproperty
  a_hold: assert property (p_hold) else $error("completion shown while sampling");
  property p_fall; $fell(o_conversion_done_n) |-> o_trial_code == '0 && !o_sample_hold; endproperty
  a_fall: assert property (p_fall) else $error("completion without a finished trial");
  property p_rise; $rose(o_conversion_done_n) |-> $past(start_low); endproperty
  a_rise: assert property (p_rise) else $error("completion cleared without a start");
  property p_oe; read_low |=> o_data_oe; endproperty
  a_oe: assert property (p_oe) else $error("data not driven during a read");
  property p_release; !o_data_oe |-> o_data == '0; endproperty
  a_release: assert property (p_release) else $error("data present while released");
  property p_clk_hi; i_clk_pin_level [*4] |=> o_conv_clk; endproperty
  a_clk_hi: assert property (p_clk_hi) else $error("steady high pin not followed");
  property p_clk_lo; !i_clk_pin_level [*4] |=> !o_conv_clk; endproperty
  a_clk_lo: assert property (p_clk_lo) else $error("steady low pin not followed");
  c_start: cover property (start_low);
  c_done: cover property ($fell(o_conversion_done_n));
  c_read: cover property (o_data_oe);
endmodule : adc_restart_assertions
`default_nettype wire

// >>> testbench/adc_front_model.sv
// Analog comparator and self-clock source that sit beyond the block.
`timescale 1ns/10ps
`default_nettype none
module adc_front_model (
  input wire logic       i_clk,
  input wire logic [7:0] i_trial_code,
  input wire logic [7:0] i_level,
  output logic           o_comp_above,
  output var logic       o_clk_pin_level
);
  logic [1:0] div_q = 2'h0;
  logic       pin_q = 1'b0;
  // A slow square wave stands in for the RC self-clock; it runs free, as an oscillator does.
  always @(posedge i_clk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) pin_q <= !pin_q;
  end
  assign o_clk_pin_level = pin_q;
  // An ideal comparator: a trial code at or below the level keeps its bit.
  assign o_comp_above = (i_level >= i_trial_code);
endmodule : adc_front_model
`default_nettype wire

// >>> testbench/test_adc_conversion_restart_control.sv
// Self-checking bench of the conversion control block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module test_adc_conversion_restart_control;
  import adc_ctrl_pkg::*;
  logic i_clk = 1'b0, i_reset = 1'b1, comp, pin;
  host_strobe_s i_strobe = 3'b111;
  logic [7:0] level = 8'h00, trial, data;
  logic hold, done_n, oe, cclk;
  int fails = 0, checks = 0;
  adc_conversion_restart_control u_adc_conversion_restart_control (.i_clk(i_clk), .i_reset(i_reset),
    .i_ce(1'b1), .i_strobe(i_strobe), .i_clk_pin_level(pin), .i_comp_above(comp), .o_trial_code(trial),
    .o_sample_hold(hold), .o_conversion_done_n(done_n), .o_data(data), .o_data_oe(oe), .o_conv_clk(cclk));
  adc_front_model u_adc_front_model (.i_clk(i_clk), .i_trial_code(trial), .i_level(level),
    .o_comp_above(comp), .o_clk_pin_level(pin));
  // Host strobes: a start pair pulse, then a bounded wait for completion.
  task start_conv(input logic [7:0] v);
    @(posedge i_clk) begin i_strobe <= 3'b001; level <= v; end
    @(posedge i_clk) i_strobe <= 3'b111;
  endtask : start_conv
  task wait_done;
    repeat (2) @(posedge i_clk);
    #1 `CHK(done_n, 1'b1)
    for (int n = 0; n < 400 && done_n !== 1'b0; n++) @(posedge i_clk);
    #1 `CHK(done_n, 1'b0)
  endtask : wait_done
  task read_check(input logic [7:0] v);
    @(posedge i_clk) i_strobe <= 3'b010;
    repeat (2) @(posedge i_clk);
    #1 `CHK(oe, 1'b1)
    `CHK(data, v)
    @(posedge i_clk) i_strobe <= 3'b111;
    repeat (2) @(posedge i_clk);
    #1 `CHK(oe, 1'b0)
  endtask : read_check
  // Codes at both ends of the span and one in the middle.
  task t_convert;
    logic [7:0] v [3] = '{8'h00, 8'hff, 8'hb6};
    `CHK(done_n, 1'b1)
    foreach (v[i]) begin
      start_conv(v[i]);
      wait_done();
      read_check(v[i]);
    end
    $display("done convert");
  endtask : t_convert
  // A restart mid-way must leave the old result and show no completion.
  task t_restart;
    start_conv(8'h3c);
    repeat (30) @(posedge i_clk);
    #1 `CHK(done_n, 1'b1)
    read_check(8'hb6);
    start_conv(8'h5a);
    repeat (20) @(posedge i_clk);
    #1 `CHK(done_n, 1'b1)
    wait_done();
    read_check(8'h5a);
    $display("done restart");
  endtask : t_restart
  // Free running: select held low, start fed from done, one forced low pulse to launch the loop.
  task t_free_run;
    int falls;
    logic prev;
    falls = 0;
    prev = done_n;
    @(posedge i_clk) begin i_strobe <= 3'b001; level <= 8'h96; end
    for (int n = 0; n < 1000 && falls < 3; n++) begin
      @(posedge i_clk);
      if (prev === 1'b1 && done_n === 1'b0) falls++;
      prev = done_n;
      i_strobe <= (falls < 3) ? {1'b0, done_n, 1'b1} : 3'b111;
    end
    #1 `CHK(falls, 3)
    `CHK(done_n, 1'b0)
    read_check(8'h96);
    $display("done free run");
  endtask : t_free_run
  // Host routine: sixteen conversions stored to consecutive slots, then checked.
  task t_sixteen;
    logic [7:0] mem [16];
    for (int i = 0; i < 16; i++) begin
      start_conv(8'(8'h11 * i));
      wait_done();
      @(posedge i_clk) i_strobe <= 3'b010;
      repeat (2) @(posedge i_clk);
      #1 mem[i] = data;
      @(posedge i_clk) i_strobe <= 3'b111;
    end
    foreach (mem[i]) `CHK(mem[i], 8'(8'h11 * i))
    $display("done sixteen");
  endtask : t_sixteen
  task stop_test;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial forever #5 i_clk = !i_clk;
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    t_convert();
    t_restart();
    t_free_run();
    t_sixteen();
    stop_test();
  end
  // About twenty-five conversions need roughly 2200 cycles; a hang is cut at 20000.
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    stop_test();
  end
endmodule : test_adc_conversion_restart_control
bind adc_conversion_restart_control adc_restart_assertions #(.RES_W(RES_W)) u_adc_restart_assertions (
  .i_clk(i_clk), .i_reset(i_reset), .i_strobe(i_strobe), .i_clk_pin_level(i_clk_pin_level),
  .o_trial_code(o_trial_code), .o_sample_hold(o_sample_hold), .o_conversion_done_n(o_conversion_done_n),
  .o_data(o_data), .o_data_oe(o_data_oe), .o_conv_clk(o_conv_clk));
`default_nettype wire
